// ===== verilog/fpio_pkg.sv
package fpio_pkg;

  // ----------------------------------------------------------------
  // Register file addresses and widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 5;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned LINES           = 4;
  localparam logic [4:0]  STATUS_FLAGS_ADDR = 5'h03;
  localparam logic [4:0]  PORT_PINS_ADDR    = 5'h06;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PIN_WAKE_FLAG_BIT = 7;
  localparam int unsigned CMP_WAKE_FLAG_BIT = 6;
  localparam int unsigned WAKE_DISABLE_BIT  = 7;
  localparam int unsigned PULLUP_DISABLE_BIT = 6;
  localparam int unsigned TIMER_SRC_BIT     = 5;
  localparam int unsigned LINE_ZERO         = 0;
  localparam int unsigned LINE_ONE          = 1;
  localparam int unsigned LINE_TWO          = 2;
  localparam int unsigned LINE_THREE        = 3;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [3:0]  PIN_DIRECTION_RST = 4'hf;
  localparam logic [7:0]  OPTION_CONFIG_RST = 8'hff;
  localparam logic [3:0]  UNUSED_HIGH_BITS  = 4'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Plain register access from the core
  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [4:0]       addr;
    logic [7:0]       wdata;
  } fpio_bus_req_type;

  // Port-specific instructions; acc is the working accumulator
  typedef struct packed {
    logic             direction_load;
    logic             option_load;
    logic             bit_set_instr;
    logic             bit_clear_instr;
    logic [2:0]       bit_sel;
    logic [7:0]       acc;
  } fpio_instr_type;

  // Alternate functions sharing the lines
  typedef struct packed {
    logic             cmp_inputs_en;
    logic             cmp_out_en;
    logic             comparator_result_out;
    logic             osc_out_en;
    logic             osc_quarter_out;
    logic             master_clear_en;
  } fpio_alt_type;

  // Why the last reset happened
  typedef struct packed {
    logic             wake_pin;
    logic             wake_cmp;
  } fpio_cause_type;

endpackage

// ===== verilog/fpio_pin_mux.sv
`timescale 1ns/1ps
module fpio_pin_mux
  import fpio_pkg::*;
#(
  parameter int unsigned N = 4
) (
  input  wire logic [N-1:0]          latch,
  input  wire logic [N-1:0]          dir,
  input  wire logic                  timer_ext_sel,
  input  wire fpio_pkg::fpio_alt_type alt,
  output logic      [N-1:0]          pin_out,
  output logic      [N-1:0]          pin_oe
);

  // ----------------------------------------------------------------
  // Per-line ownership, highest priority first
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_line
      always_comb begin
        pin_out[i] = latch[i];
        pin_oe[i]  = ~dir[i];
        if (i == LINE_THREE) begin
          pin_oe[i] = 1'b0;                      // input only
        end else if (i == LINE_TWO) begin
          if (alt.osc_out_en) begin
            pin_out[i] = alt.osc_quarter_out;
            pin_oe[i]  = 1'b1;
          end else if (alt.cmp_out_en) begin
            pin_out[i] = alt.comparator_result_out;
            pin_oe[i]  = 1'b1;
          end else if (timer_ext_sel) begin
            pin_oe[i]  = 1'b0;                   // timer clock in
          end
        end else if (alt.cmp_inputs_en) begin
          pin_oe[i] = 1'b0;                      // comparator inputs
        end
      end
    end
  endgenerate

endmodule

// ===== verilog/fpio_wake_detect.sv
`timescale 1ns/1ps
module fpio_wake_detect
  import fpio_pkg::*;
#(
  parameter int unsigned N = 4
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [N-1:0] pins,
  input  wire logic         snap,
  input  wire logic [N-1:0] mask,
  output logic              change
);

  logic [N-1:0] last_read;

  // ----------------------------------------------------------------
  // Reference levels taken at each port read
  // ----------------------------------------------------------------
  // Change is judged against what software last saw, not last cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_read <= '0;
    end else if (snap) begin
      last_read <= pins;
    end
  end

  // Any enabled line that differs asks for wake
  assign change = |((pins ^ last_read) & mask);

endmodule

// ===== verilog/fpio_port.sv
`timescale 1ns/1ps
// Overview of operation
// - Port reads return pin levels, never output latch contents.
// - Every reset sets all direction bits: all lines become inputs.
// - Port register is eight bits; upper four read as zero.
// - Line three is input only; its direction bit does nothing.
// - Lines zero, one, three share one pull-up and one wake control.
// - Master clear on line three: pull-up forced on, its wake off.
// - Direction loads only by direction_load from accumulator; not readable.
// - Direction one floats the driver; zero drives the latch value.
// - Fixed pin priority: oscillator, comparator, timer clock, direction.
// - Inputs unlatched, sampled at read; output latches hold until written.
// - Lines zero to two each have an independent direction bit.
// - Status bit 7 set after pin-change wake reset, else cleared.
// - Status bit 6 set after comparator wake reset, else cleared.
// - Bit set/clear read all pins, modify one, write all latches.
// - Output latches unknown at power-on, kept across other resets.
// - Writes land at cycle end; reads sample at cycle start.
// - Oscillator-output control puts clock over four on line two.
module fpio_port
  import fpio_pkg::*;
#(
  parameter int unsigned N = LINES
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire fpio_pkg::fpio_bus_req_type bus_req,
  input  wire fpio_pkg::fpio_instr_type   instr,
  input  wire fpio_pkg::fpio_alt_type     alt,
  input  wire fpio_pkg::fpio_cause_type   cause,
  input  wire logic      [N-1:0]         pin_in,
  output logic           [N-1:0]         pin_out,
  output logic           [N-1:0]         pin_oe,
  output logic           [N-1:0]         pullup_en,
  output logic           [7:0]           rd_data,
  output logic                           rd_valid,
  output logic           [7:0]           option_out,
  output logic                           timer_ext_clock_in,
  output logic                           pin_change_wake
);
  import fpio_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [N-1:0] out_latch;
  logic [N-1:0] pin_direction;
  logic [7:0]   option_config;
  logic         pin_wake_flag;
  logic         comparator_wake_flag;
  logic         cause_taken;
  logic [N-1:0] next_latch;
  logic         latch_load;
  logic [N-1:0] wake_mask;
  logic [N-1:0] rmw_image;
  logic         port_read;
  logic         port_write;
  logic         status_write;
  logic         status_read;
  logic         pullup_on;
  logic         wake_on;
  logic         timer_ext_sel;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign port_read    = bus_req.rd && (bus_req.addr == PORT_PINS_ADDR);
  assign port_write   = bus_req.wr && (bus_req.addr == PORT_PINS_ADDR);
  assign status_read  = bus_req.rd && (bus_req.addr == STATUS_FLAGS_ADDR);
  assign status_write = bus_req.wr && (bus_req.addr == STATUS_FLAGS_ADDR);

  // ----------------------------------------------------------------
  // Direction register
  // ----------------------------------------------------------------
  // Only the dedicated instruction reaches it; no read path exists
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_direction <= PIN_DIRECTION_RST;
    end else if (instr.direction_load) begin
      pin_direction <= instr.acc[N-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Option register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      option_config <= OPTION_CONFIG_RST;
    end else if (instr.option_load) begin
      option_config <= instr.acc;
    end
  end

  assign option_out = option_config;
  // Active-low shared enables
  assign pullup_on  = ~option_config[PULLUP_DISABLE_BIT];
  assign wake_on    = ~option_config[WAKE_DISABLE_BIT];
  assign timer_ext_sel = option_config[TIMER_SRC_BIT];

  // ----------------------------------------------------------------
  // Output latches
  // ----------------------------------------------------------------
  // Read-modify-write image: pins as they stand, one bit changed
  always_comb begin
    rmw_image = pin_in;
    if (instr.bit_sel < 3'(N)) begin
      rmw_image[instr.bit_sel[1:0]] = instr.bit_set_instr;
    end
  end

  // Plain write beats bit op if both arrive together
  always_comb begin
    latch_load = 1'b1;
    next_latch = out_latch;
    if (port_write) begin
      next_latch = bus_req.wdata[N-1:0];
    end else if (instr.bit_set_instr || instr.bit_clear_instr) begin
      next_latch = rmw_image;
    end else begin
      latch_load = 1'b0;
    end
  end

  // No reset on purpose: latches survive warm resets
  // Write takes effect at the edge closing the cycle
  always_ff @(posedge clk) begin
    if (latch_load) begin
      out_latch <= next_latch;
    end
  end

  // ----------------------------------------------------------------
  // Wake cause flags
  // ----------------------------------------------------------------
  // Cause is a port level, so it is caught on the first edge after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cause_taken <= 1'b0;
    end else begin
      cause_taken <= 1'b1;
    end
  end

  // Capture wins over a software write in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_wake_flag <= 1'b0;
    end else if (!cause_taken) begin
      pin_wake_flag <= cause.wake_pin;
    end else if (status_write) begin
      pin_wake_flag <= bus_req.wdata[PIN_WAKE_FLAG_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comparator_wake_flag <= 1'b0;
    end else if (!cause_taken) begin
      comparator_wake_flag <= cause.wake_cmp;
    end else if (status_write) begin
      comparator_wake_flag <= bus_req.wdata[CMP_WAKE_FLAG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Pins are sampled at the edge that opens the read; no input latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else if (port_read) begin
      rd_data <= {UNUSED_HIGH_BITS, pin_in};
    end else if (status_read) begin
      rd_data <= {pin_wake_flag, comparator_wake_flag, 6'h00};
    end else if (bus_req.rd) begin
      rd_data <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= bus_req.rd;
    end
  end

  // ----------------------------------------------------------------
  // Pull-ups and wake mask
  // ----------------------------------------------------------------
  // One shared switch for lines zero, one and three
  always_comb begin
    pullup_en = '0;
    wake_mask = '0;
    pullup_en[LINE_ZERO]  = pullup_on;
    pullup_en[LINE_ONE]   = pullup_on;
    pullup_en[LINE_THREE] = pullup_on || alt.master_clear_en;
    wake_mask[LINE_ZERO]  = wake_on;
    wake_mask[LINE_ONE]   = wake_on;
    wake_mask[LINE_THREE] = wake_on && !alt.master_clear_en;
  end

  fpio_wake_detect #(
    .N      (N)
  ) u_wake (
    .clk    (clk),
    .rstn   (rstn),
    .pins   (pin_in),
    .snap   (port_read),
    .mask   (wake_mask),
    .change (pin_change_wake)
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Direction bit of line three is stored but never used
  fpio_pin_mux #(
    .N             (N)
  ) u_mux (
    .latch         (out_latch),
    .dir           (pin_direction),
    .timer_ext_sel (timer_ext_sel),
    .alt           (alt),
    .pin_out       (pin_out),
    .pin_oe        (pin_oe)                       // driver state visible
  );

  // Timer clock comes from line two's pin level
  assign timer_ext_clock_in = timer_ext_sel && pin_in[LINE_TWO];

endmodule

// ===== sim/fpio_port_sva.sv
`timescale 1ns/1ps
module fpio_port_sva
  import fpio_pkg::*;
#(
  parameter int unsigned N = 4
) (
  input wire logic                       clk,
  input wire logic                       rstn,
  input wire fpio_pkg::fpio_bus_req_type bus_req,
  input wire fpio_pkg::fpio_instr_type   instr,
  input wire fpio_pkg::fpio_alt_type     alt,
  input wire fpio_pkg::fpio_cause_type   cause,
  input wire logic [N-1:0]               pin_in,
  input wire logic [N-1:0]               pin_out,
  input wire logic [N-1:0]               pin_oe,
  input wire logic [N-1:0]               pullup_en,
  input wire logic [7:0]                 rd_data,
  input wire logic                       rd_valid,
  input wire logic [7:0]                 option_out,
  input wire logic                       timer_ext_clock_in,
  input wire logic                       pin_change_wake
);
  // ------------------------------------------------------------
  // Port timing and pin ownership
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // First edge after release, then a status read right behind it
  sequence boot_s; $rose(rstn); endsequence
  sequence stat_rd_s; bus_req.rd && bus_req.addr == STATUS_FLAGS_ADDR; endsequence

  line3_input_a: assert property (!pin_oe[3]) else $error("line three driven");
  boot_dir_a: assert property (boot_s |-> pin_oe[1:0] == 2'h0 && (alt.osc_out_en || alt.cmp_out_en || !pin_oe[2]))
    else $error("drivers on after reset");
  wake_flags_a: assert property (boot_s ##1 stat_rd_s |=>
    rd_data[7:6] == {$past(cause.wake_pin, 2), $past(cause.wake_cmp, 2)}) else $error("wake flags wrong");
  read_pins_a: assert property (bus_req.rd && bus_req.addr == PORT_PINS_ADDR |=>
    rd_valid && rd_data == {4'h0, $past(pin_in)}) else $error("port read not pin levels");
  dir_load_a: assert property (instr.direction_load && !alt.cmp_inputs_en |=>
    pin_oe[1:0] == ~$past(instr.acc[1:0])) else $error("direction not loaded");
  osc_prio_a: assert property (alt.osc_out_en |-> pin_oe[2] && pin_out[2] == alt.osc_quarter_out)
    else $error("line two not oscillator");
  cmp_in_a: assert property (alt.cmp_inputs_en |-> pin_oe[1:0] == 2'h0) else $error("cmp inputs driven");
  timer_float_a: assert property (option_out[TIMER_SRC_BIT] && !alt.osc_out_en && !alt.cmp_out_en
    |-> !pin_oe[2]) else $error("timer input driven");
  pullup_a: assert property (pullup_en == {!option_out[6] || alt.master_clear_en, 1'b0, {2{!option_out[6]}}})
    else $error("pull-up mapping wrong");
endmodule

bind fpio_port fpio_port_sva #(.N(N)) fpio_port_sva_i (.clk, .rstn, .bus_req, .instr, .alt, .cause, .pin_in,
  .pin_out, .pin_oe, .pullup_en, .rd_data, .rd_valid, .option_out, .timer_ext_clock_in, .pin_change_wake);

// ===== sim/fpio_pins_model.sv
`timescale 1ns/1ps
module fpio_pins_model (
  input  wire logic       clk,
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] pullup_en,
  input  wire logic [3:0] ext_en,
  input  wire logic [3:0] ext_val,
  output logic      [3:0] pin_in
);
  logic drift = 1'b0;

  // Floating lines wander so a stale level is never read as good
  always @(posedge clk) drift <= ~drift;

  // Port drive wins; outside drive only on released lines
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = drift ^ i[0];
    end
  end
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
  import fpio_pkg::*;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  fpio_bus_req_type bus_req = '0;
  fpio_instr_type   instr = '0;
  fpio_alt_type     alt = '0;
  fpio_cause_type   cause = '0;
  logic [3:0]       ext_en = 4'hf;
  logic [3:0]       ext_val = 4'h0;
  logic [3:0]       pin_in, pin_out, pin_oe, pullup_en;
  logic [7:0]       rd_data, option_out, rv;
  logic             rd_valid, timer_ext_clock_in, pin_change_wake;
  int               errors = 0;
  int               n_checks = 0;

  // 10 MHz instruction clock
  initial begin
    forever #50 clk = ~clk;
  end

  fpio_port fpio_port_i (.clk, .rstn, .bus_req, .instr, .alt, .cause, .pin_in, .pin_out, .pin_oe, .pullup_en,
    .rd_data, .rd_valid, .option_out, .timer_ext_clock_in, .pin_change_wake);
  fpio_pins_model fpio_pins_model_i (.clk, .pin_out, .pin_oe, .pullup_en, .ext_en, .ext_val, .pin_in);

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [4:0] a);
    @(negedge clk);
    bus_req = '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk);
    bus_req = '0;
    rv = rd_data;
    chk({7'h0, rd_valid}, 8'h01);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_req = '{1'b0, 1'b1, a, d};
    @(negedge clk);
    bus_req = '0;
  endtask

  // Kind 0 direction load, 1 option load, 2 bit set, 3 bit clear
  task automatic op(input int k, input logic [2:0] b, input logic [7:0] a);
    @(negedge clk);
    instr = '{k == 0, k == 1, k == 2, k == 3, b, a};
    @(negedge clk);
    instr = '0;
  endtask

  task automatic do_reset(input int n, input fpio_cause_type c);
    @(negedge clk);
    rstn = 1'b0;
    cause = c;
    repeat (n) @(negedge clk);
    rstn = 1'b1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_boot;
    do_reset(11, '{1'b1, 1'b0});
    rd(STATUS_FLAGS_ADDR);
    chk(rv, 8'h80);
    cause = '0;
    chk({4'h0, pin_oe}, 8'h00);
    chk(option_out, 8'hff);
    rd(5'h1f);
    chk(rv, 8'h00);
    op(1, 3'h0, 8'hdf);
  endtask

  task automatic t_read_pins;
    ext_val = 4'ha;
    wr(PORT_PINS_ADDR, 8'hf5);
    rd(PORT_PINS_ADDR);
    chk(rv, 8'h0a);
    ext_en = 4'h8;
    op(0, 3'h0, 8'h00);
    chk({4'h0, pin_oe}, 8'h07);
    chk({5'h0, pin_out[2:0]}, 8'h05);
    rd(PORT_PINS_ADDR);
    chk(rv, 8'h0d);
    op(0, 3'h0, 8'h0a);
    chk({4'h0, pin_oe}, 8'h05);
  endtask

  // Clearing line zero rewrites line one's latch from its pin
  task automatic t_rmw;
    ext_en = 4'ha;
    op(3, 3'h0, 8'h00);
    ext_en = 4'h8;
    op(0, 3'h0, 8'h00);
    chk({5'h0, pin_out[2:0]}, 8'h06);
  endtask

  task automatic t_alt;
    @(negedge clk);
    alt = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    #1 chk({6'h0, pin_oe[2], pin_out[2]}, 8'h02);
    @(negedge clk);
    alt = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    #1 chk({6'h0, pin_oe[2], pin_out[2]}, 8'h02);
    @(negedge clk);
    alt = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    op(1, 3'h0, 8'hff);
    chk({4'h0, pin_oe}, 8'h00);
    alt = '0;
    // Timer source still selected: line two floats and feeds the timer clock
    ext_en = 4'hc;
    ext_val = 4'h4;
    #1 chk({7'h0, timer_ext_clock_in}, 8'h01);
    @(negedge clk);
    ext_val = 4'h8;
    #1 chk({7'h0, timer_ext_clock_in}, 8'h00);
  endtask

  task automatic t_pull_wake;
    op(0, 3'h0, 8'hff);
    ext_en = 4'hf;
    ext_val = 4'h0;
    op(1, 3'h0, 8'h00);
    chk({4'h0, pullup_en}, 8'h0b);
    rd(PORT_PINS_ADDR);
    ext_val = 4'h4;
    @(negedge clk);
    chk({7'h0, pin_change_wake}, 8'h00);
    ext_val = 4'h1;
    @(negedge clk);
    chk({7'h0, pin_change_wake}, 8'h01);
    ext_val = 4'h0;
    op(1, 3'h0, 8'h40);
    alt.master_clear_en = 1'b1;
    ext_val = 4'h8;
    @(negedge clk);
    chk({4'h0, pullup_en}, 8'h08);
    chk({7'h0, pin_change_wake}, 8'h00);
    alt.master_clear_en = 1'b0;
    @(negedge clk);
    chk({7'h0, pin_change_wake}, 8'h01);
  endtask

  // Latches survive a warm reset; direction does not
  task automatic t_warm;
    ext_en = 4'h8;
    op(0, 3'h0, 8'h00);
    wr(PORT_PINS_ADDR, 8'h03);
    do_reset(3, '{1'b0, 1'b1});
    rd(STATUS_FLAGS_ADDR);
    chk(rv, 8'h40);
    cause = '0;
    chk({4'h0, pin_oe}, 8'h00);
    op(1, 3'h0, 8'hdf);
    op(0, 3'h0, 8'h00);
    chk({5'h0, pin_out[2:0]}, 8'h03);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    t_boot;
    t_read_pins;
    t_rmw;
    t_alt;
    t_pull_wake;
    t_warm;
    report_and_stop;
  end

  // Watchdog: tests take about 65 cycles, allow 2000
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
endmodule
